// ---- hw/dld_map.svh ----
// register map, field positions, reset values and time constants of the load diagnostic control
`ifndef DLD_MAP_SVH
`define DLD_MAP_SVH

// register offsets
`define DLD_OFS_STATE      8'h04
`define DLD_OFS_MAIN       8'h05
`define DLD_OFS_AVG        8'h06
`define DLD_OFS_RAMP       8'h07
`define DLD_OFS_THRESH     8'h08
`define DLD_OFS_RPT12      8'h0A
`define DLD_OFS_RPT34      8'h0B
`define DLD_OFS_RPTLO      8'h0C

// reset values
`define DLD_RST_STATE      8'h55
`define DLD_RST_MAIN       8'h00
`define DLD_RST_AVG        8'h00
`define DLD_RST_RAMP       8'h00
`define DLD_RST_THRESH     8'h11

// main control fields
`define DLD_BIT_ABORT      7
`define DLD_BUFW_HI        6
`define DLD_BUFW_LO        5
`define DLD_BIT_END_SKIP   2
`define DLD_BIT_DET_OFF    1
`define DLD_BIT_AUTO_SKIP  0

// averaging / line-out fields
`define DLD_BIT_RAIL_AVG   6
`define DLD_LAVG_HI        5
`define DLD_LAVG_LO        4
`define DLD_LO_TOP         3

// ramp / settle fields
`define DLD_LRAMP_HI       7
`define DLD_LRAMP_LO       6
`define DLD_LSET_HI        5
`define DLD_LSET_LO        4
`define DLD_RRAMP_HI       3
`define DLD_RRAMP_LO       2
`define DLD_RSET_HI        1
`define DLD_RSET_LO        0

// threshold fields
`define DLD_TH1_HI         7
`define DLD_TH1_LO         4
`define DLD_TH2_HI         3
`define DLD_TH2_LO         0

// channel state code that requests a diagnostic
`define DLD_STATE_DIAG     2'h3

// clock rate in MHz (cycles per microsecond)
`define DLD_CLK_MHZ        8'h7D

// times in microseconds
`define DLD_T_0P2MS_US     16'h00C8
`define DLD_T_0P7MS_US     16'h02BC
`define DLD_T_1MS_US       16'h03E8
`define DLD_T_2MS_US       16'h07D0
`define DLD_T_2P5MS_US     16'h09C4
`define DLD_T_5MS_US       16'h1388
`define DLD_T_10MS_US      16'h2710
`define DLD_T_10P7MS_US    16'h29CC
`define DLD_T_15MS_US      16'h3A98
`define DLD_T_20MS_US      16'h4E20
`define DLD_T_21P3MS_US    16'h5334
`define DLD_T_30MS_US      16'h7530
`define DLD_T_42P7MS_US    16'hA6CC

`endif

// ---- hw/dld_pkg.sv ----
// types of the load diagnostic control
package dld_pkg;

   // sequencer states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE        = 9'h001,
      ST_BUF_WAIT    = 9'h002,
      ST_RAIL_RAMP   = 9'h004,
      ST_RAIL_SETTLE = 9'h008,
      ST_RAIL_AVG    = 9'h010,
      ST_LOAD_RAMP   = 9'h020,
      ST_LOAD_SETTLE = 9'h040,
      ST_LOAD_AVG    = 9'h080,
      ST_END_WAIT    = 9'h100
   } dld_state_type;

   typedef logic [15:0] dld_time_type;

endpackage

// ---- hw/dld_tmr_if.sv ----
// interval timer link between the sequencer and its timer
`timescale 1ns/10ps
interface dld_tmr_if;
   logic                   start;
   logic                   stop;
   logic [15:0]            time_us;
   logic                   done;

   modport ctrl (output start, output stop, output time_us, input done);
   modport tmr  (input start, input stop, input time_us, output done);
endinterface

// ---- hw/dld_timer.sv ----
// microsecond interval timer with cycle prescaler
`timescale 1ns/10ps
`include "dld_map.svh"
module dld_timer
   import dld_pkg::*;
#(
   parameter logic [7:0] CYC_PER_US = `DLD_CLK_MHZ
) (
   // clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // sequencer side
   dld_tmr_if.tmr         t
);

   logic                   run;
   logic [7:0]             pre;
   dld_time_type           us_left;

   // count whole microseconds; one start restarts, stop wins over everything
   always_ff @(posedge clk) begin
      if (rst || t.stop) begin
         run     <= 1'b0;
         pre     <= 8'h00;
         us_left <= 16'h0000;
         t.done  <= 1'b0;
      end else if (t.start) begin
         run     <= 1'b1;
         pre     <= 8'h00;
         us_left <= t.time_us;
         t.done  <= 1'b0;
      end else begin
         t.done <= 1'b0;
         if (run) begin
            if (pre == CYC_PER_US - 8'h01) begin // cycles derived from the clock rate
               pre <= 8'h00;
               if (us_left <= 16'h0001) begin
                  run    <= 1'b0;
                  t.done <= 1'b1;
               end else begin
                  us_left <= us_left - 16'h0001;
               end
            end else begin
               pre <= pre + 8'h01;
            end
         end
      end
   end

endmodule // dld_timer

// ---- hw/dld_top.sv ----
// DC load diagnostic control: registers, request collection, sequencer and result flags
//
// Behaviour
// [R01] abort bit 7 set ends any running diagnostic; clear means normal operation
// [R02] buffer wait field selects 1, 2, 5 or 10 ms
// [R03] wait-bypass bit 2 clear runs the end waiting loop; set skips it; with detect-off bit 1 set the loop is skipped either way
// [R04] detect-off bit 1 skips shorted, open and line-out detection
// [R05] auto bypass bit 0 clear starts diagnostics on Hi-Z exit or fault
// [R06] rail short averaging is 0.2 ms when bit 6 is 0, else 0.7 ms
// [R07] load averaging field: rail time, 10.7, 21.3 or 42.7 ms
// [R08] line-out check per channel only when its enable bit is set, bit 3 ch1
// [R09] load phase ramp field gives 15, 30, 10 or 20 ms
// [R10] load phase settle field gives 10, 5, 20 or 15 ms
// [R11] rail phase ramp field gives 5, 2.5, 10 or 15 ms
// [R12] rail phase settle field gives 10, 5, 20 or 30 ms
// [R13] channel 1 and 2 four-bit short thresholds, default code 0001
// [R14] writing state code 11 for a channel starts its diagnostic
// [R15] read-only result flags per channel, channel 1 ground short at bit 7
// [R16] rail phase before load phase, each ramp then settle then average
// [R17] intervals counted in clock cycles from configured millisecond values
`timescale 1ns/10ps
`include "dld_map.svh"
module dld_top
   import dld_pkg::*;
#(
   parameter logic [7:0] CYC_PER_US = `DLD_CLK_MHZ
) (
   // clock and reset
   input  wire logic         CLOCK,
   input  wire logic         SYS_RST,
   // register port
   input  wire logic [7:0]   REG_ADDR,
   input  wire logic [7:0]   REG_WDATA,
   input  wire logic         REG_WE,
   input  wire logic         REG_RE,
   output logic      [7:0]   REG_RDATA,
   // channel events from the output stages
   input  wire logic [3:0]   CH_HIZ_EXIT,
   input  wire logic [3:0]   CH_FAULT,
   // measurement results from the analog front end
   input  wire logic [3:0]   MEAS_GND_SHORT,
   input  wire logic [3:0]   MEAS_SUPPLY_SHORT,
   input  wire logic [3:0]   MEAS_OPEN,
   input  wire logic [3:0]   MEAS_SHORTED,
   input  wire logic [3:0]   MEAS_LINEOUT,
   // diagnostic control toward the output stages
   output logic              DIAG_BUSY,
   output logic              DIAG_DONE,
   output logic [3:0]        DIAG_CH,
   output logic              PHASE_LOAD,
   output logic              STEP_RAMP,
   output logic              STEP_SETTLE,
   output logic              STEP_AVG,
   output logic [3:0]        LINEOUT_CHECK,
   output logic [3:0]        SHORT_THRESH_1,
   output logic [3:0]        SHORT_THRESH_2
);

   logic [7:0]             chan_state;
   logic [7:0]             ctrl_main;
   logic [7:0]             ctrl_avg;
   logic [7:0]             ctrl_ramp;
   logic [7:0]             ctrl_thresh;
   logic [3:0]             gnd_flag;
   logic [3:0]             sup_flag;
   logic [3:0]             open_flag;
   logic [3:0]             shrt_flag;
   logic [3:0]             lo_flag;
   logic [3:0]             pend;
   logic [3:0]             new_req;
   logic [3:0]             lo_en;
   dld_state_type          state;
   dld_state_type          next_state;
   dld_time_type           next_time;
   dld_time_type           rail_avg_t;
   logic                   diag_abort;
   logic                   diag_end_wait_skip;
   logic                   diag_load_detect_off;
   logic                   diag_auto_run_skip;
   logic                   wr_state;
   logic                   take;
   logic                   finish;

   dld_tmr_if tmr ();

   dld_timer #(
      .CYC_PER_US (CYC_PER_US)
   ) u_timer (
      .clk (CLOCK),
      .rst (SYS_RST),
      .t   (tmr)
   );

   assign diag_abort           = ctrl_main[`DLD_BIT_ABORT];
   assign diag_end_wait_skip   = ctrl_main[`DLD_BIT_END_SKIP];
   assign diag_load_detect_off = ctrl_main[`DLD_BIT_DET_OFF];
   assign diag_auto_run_skip   = ctrl_main[`DLD_BIT_AUTO_SKIP];
   assign wr_state             = REG_WE && (REG_ADDR == `DLD_OFS_STATE);
   assign take                 = (state == ST_IDLE) && (next_state == ST_BUF_WAIT);
   assign finish               = (state != ST_IDLE) && (next_state == ST_IDLE) && !diag_abort;

   // writable registers; reserved bits are kept as read/write storage
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         chan_state  <= `DLD_RST_STATE;
         ctrl_main   <= `DLD_RST_MAIN;
         ctrl_avg    <= `DLD_RST_AVG;
         ctrl_ramp   <= `DLD_RST_RAMP;
         ctrl_thresh <= `DLD_RST_THRESH; // [R13]
      end else if (REG_WE) begin
         unique case (REG_ADDR)
            `DLD_OFS_STATE:  chan_state  <= REG_WDATA;
            `DLD_OFS_MAIN:   ctrl_main   <= REG_WDATA;
            `DLD_OFS_AVG:    ctrl_avg    <= REG_WDATA;
            `DLD_OFS_RAMP:   ctrl_ramp   <= REG_WDATA;
            `DLD_OFS_THRESH: ctrl_thresh <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // per-channel requests, line-out enables and result flags
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         // channel gi+1 owns state field bits [7-2gi:6-2gi]
         assign new_req[gi] = (wr_state && (REG_WDATA[7-2*gi -: 2] == `DLD_STATE_DIAG)) || // [R14]
                              (!diag_auto_run_skip && (CH_HIZ_EXIT[gi] || CH_FAULT[gi])); // [R05]
         assign lo_en[gi]   = ctrl_avg[`DLD_LO_TOP-gi]; // [R08]

         // flags clear when a run takes the channel and set at the end of averaging
         always_ff @(posedge CLOCK) begin
            if (SYS_RST) begin
               gnd_flag[gi]  <= 1'b0;
               sup_flag[gi]  <= 1'b0;
               open_flag[gi] <= 1'b0;
               shrt_flag[gi] <= 1'b0;
               lo_flag[gi]   <= 1'b0;
            end else if (take && pend[gi]) begin
               gnd_flag[gi]  <= 1'b0;
               sup_flag[gi]  <= 1'b0;
               open_flag[gi] <= 1'b0;
               shrt_flag[gi] <= 1'b0;
               lo_flag[gi]   <= 1'b0;
            end else if (DIAG_CH[gi] && tmr.done && !diag_abort) begin
               if (state == ST_RAIL_AVG) begin
                  gnd_flag[gi] <= MEAS_GND_SHORT[gi]; // [R15]
                  sup_flag[gi] <= MEAS_SUPPLY_SHORT[gi];
               end
               if (state == ST_LOAD_AVG) begin
                  open_flag[gi] <= MEAS_OPEN[gi];
                  shrt_flag[gi] <= MEAS_SHORTED[gi];
                  lo_flag[gi]   <= MEAS_LINEOUT[gi] && lo_en[gi]; // [R08]
               end
            end
         end
      end
   endgenerate

   // pending channels; a new request wins over the clear at take
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || diag_abort) begin
         pend <= 4'h0; // [R01]
      end else begin
         pend <= (pend & ~(take ? pend : 4'h0)) | new_req;
      end
   end

   // sequencer next state: rail phase first, then load phase
   always_comb begin
      next_state = state;
      if (diag_abort) begin
         next_state = ST_IDLE; // [R01]
      end else begin
         unique case (state)
            ST_IDLE:        if (pend != 4'h0) next_state = ST_BUF_WAIT;
            ST_BUF_WAIT:    if (tmr.done) next_state = ST_RAIL_RAMP; // [R16]
            ST_RAIL_RAMP:   if (tmr.done) next_state = ST_RAIL_SETTLE;
            ST_RAIL_SETTLE: if (tmr.done) next_state = ST_RAIL_AVG;
            ST_RAIL_AVG:    if (tmr.done) next_state = diag_load_detect_off ? ST_IDLE : ST_LOAD_RAMP; // [R04]
            ST_LOAD_RAMP:   if (tmr.done) next_state = ST_LOAD_SETTLE;
            ST_LOAD_SETTLE: if (tmr.done) next_state = ST_LOAD_AVG;
            ST_LOAD_AVG:    if (tmr.done) next_state = diag_end_wait_skip ? ST_IDLE : ST_END_WAIT; // [R03]
            ST_END_WAIT:    if (tmr.done) next_state = ST_IDLE;
            default:        next_state = ST_IDLE;
         endcase
      end
   end

   // interval for the state being entered
   always_comb begin
      rail_avg_t = ctrl_avg[`DLD_BIT_RAIL_AVG] ? `DLD_T_0P7MS_US : `DLD_T_0P2MS_US; // [R06]
      next_time  = `DLD_T_1MS_US;
      unique case (next_state)
         ST_BUF_WAIT, ST_END_WAIT: begin
            // the end loop reuses the buffer wait length
            unique case (ctrl_main[`DLD_BUFW_HI:`DLD_BUFW_LO]) // [R02]
               2'h0: next_time = `DLD_T_1MS_US;
               2'h1: next_time = `DLD_T_2MS_US;
               2'h2: next_time = `DLD_T_5MS_US;
               2'h3: next_time = `DLD_T_10MS_US;
            endcase
         end
         ST_RAIL_RAMP: begin
            unique case (ctrl_ramp[`DLD_RRAMP_HI:`DLD_RRAMP_LO]) // [R11]
               2'h0: next_time = `DLD_T_5MS_US;
               2'h1: next_time = `DLD_T_2P5MS_US;
               2'h2: next_time = `DLD_T_10MS_US;
               2'h3: next_time = `DLD_T_15MS_US;
            endcase
         end
         ST_RAIL_SETTLE: begin
            unique case (ctrl_ramp[`DLD_RSET_HI:`DLD_RSET_LO]) // [R12]
               2'h0: next_time = `DLD_T_10MS_US;
               2'h1: next_time = `DLD_T_5MS_US;
               2'h2: next_time = `DLD_T_20MS_US;
               2'h3: next_time = `DLD_T_30MS_US;
            endcase
         end
         ST_RAIL_AVG: next_time = rail_avg_t; // [R06]
         ST_LOAD_RAMP: begin
            unique case (ctrl_ramp[`DLD_LRAMP_HI:`DLD_LRAMP_LO]) // [R09]
               2'h0: next_time = `DLD_T_15MS_US;
               2'h1: next_time = `DLD_T_30MS_US;
               2'h2: next_time = `DLD_T_10MS_US;
               2'h3: next_time = `DLD_T_20MS_US;
            endcase
         end
         ST_LOAD_SETTLE: begin
            unique case (ctrl_ramp[`DLD_LSET_HI:`DLD_LSET_LO]) // [R10]
               2'h0: next_time = `DLD_T_10MS_US;
               2'h1: next_time = `DLD_T_5MS_US;
               2'h2: next_time = `DLD_T_20MS_US;
               2'h3: next_time = `DLD_T_15MS_US;
            endcase
         end
         ST_LOAD_AVG: begin
            unique case (ctrl_avg[`DLD_LAVG_HI:`DLD_LAVG_LO]) // [R07]
               2'h0: next_time = rail_avg_t;
               2'h1: next_time = `DLD_T_10P7MS_US;
               2'h2: next_time = `DLD_T_21P3MS_US;
               2'h3: next_time = `DLD_T_42P7MS_US;
            endcase
         end
         default: next_time = `DLD_T_1MS_US;
      endcase
   end

   // state register and timer launch; the timer starts one cycle after entry
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         state       <= ST_IDLE;
         tmr.start   <= 1'b0;
         tmr.stop    <= 1'b1;
         tmr.time_us <= `DLD_T_1MS_US;
      end else begin
         state       <= next_state;
         tmr.start   <= (next_state != state) && (next_state != ST_IDLE); // [R17]
         tmr.stop    <= diag_abort; // [R01]
         tmr.time_us <= next_time; // [R17]
      end
   end

   // outputs toward the output stages, all registered
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         DIAG_BUSY      <= 1'b0;
         DIAG_DONE      <= 1'b0;
         DIAG_CH        <= 4'h0;
         PHASE_LOAD     <= 1'b0;
         STEP_RAMP      <= 1'b0;
         STEP_SETTLE    <= 1'b0;
         STEP_AVG       <= 1'b0;
         LINEOUT_CHECK  <= 4'h0;
         SHORT_THRESH_1 <= 4'(`DLD_RST_THRESH >> `DLD_TH1_LO);
         SHORT_THRESH_2 <= 4'(`DLD_RST_THRESH);
      end else begin
         DIAG_BUSY      <= next_state != ST_IDLE;
         DIAG_DONE      <= finish;
         if (take) begin
            DIAG_CH <= pend;
         end else if (next_state == ST_IDLE) begin
            DIAG_CH <= 4'h0;
         end
         PHASE_LOAD     <= next_state inside {ST_LOAD_RAMP, ST_LOAD_SETTLE, ST_LOAD_AVG};
         STEP_RAMP      <= next_state inside {ST_RAIL_RAMP, ST_LOAD_RAMP};
         STEP_SETTLE    <= next_state inside {ST_RAIL_SETTLE, ST_LOAD_SETTLE};
         STEP_AVG       <= next_state inside {ST_RAIL_AVG, ST_LOAD_AVG};
         LINEOUT_CHECK  <= (next_state == ST_LOAD_AVG) ? (lo_en & DIAG_CH) : 4'h0; // [R08]
         SHORT_THRESH_1 <= ctrl_thresh[`DLD_TH1_HI:`DLD_TH1_LO]; // [R13]
         SHORT_THRESH_2 <= ctrl_thresh[`DLD_TH2_HI:`DLD_TH2_LO];
      end
   end

   // read data, one cycle after the read strobe; unmapped reads give zero
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RE) begin
         unique case (REG_ADDR)
            `DLD_OFS_STATE:  REG_RDATA <= chan_state;
            `DLD_OFS_MAIN:   REG_RDATA <= ctrl_main;
            `DLD_OFS_AVG:    REG_RDATA <= ctrl_avg;
            `DLD_OFS_RAMP:   REG_RDATA <= ctrl_ramp;
            `DLD_OFS_THRESH: REG_RDATA <= ctrl_thresh;
            `DLD_OFS_RPT12:  REG_RDATA <= {gnd_flag[0], sup_flag[0], open_flag[0], shrt_flag[0],
                                           gnd_flag[1], sup_flag[1], open_flag[1], shrt_flag[1]}; // [R15]
            `DLD_OFS_RPT34:  REG_RDATA <= {gnd_flag[2], sup_flag[2], open_flag[2], shrt_flag[2],
                                           gnd_flag[3], sup_flag[3], open_flag[3], shrt_flag[3]};
            `DLD_OFS_RPTLO:  REG_RDATA <= {4'h0, lo_flag[0], lo_flag[1], lo_flag[2], lo_flag[3]};
            default:         REG_RDATA <= 8'h00;
         endcase
      end
   end

endmodule // dld_top

// ---- test/dld_chk.sv ----
// port assertions of the load diagnostic control
`timescale 1ns/10ps
module dld_chk (
   // clock and reset
   input wire logic       CLOCK,
   input wire logic       SYS_RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WE,
   // diagnostic outputs
   input wire logic       DIAG_BUSY,
   input wire logic       DIAG_DONE,
   input wire logic [3:0] DIAG_CH,
   input wire logic       PHASE_LOAD,
   input wire logic       STEP_RAMP,
   input wire logic       STEP_SETTLE,
   input wire logic       STEP_AVG,
   input wire logic [3:0] LINEOUT_CHECK,
   input wire logic [3:0] SHORT_THRESH_1,
   input wire logic [3:0] SHORT_THRESH_2
);
   logic       abort_q;
   logic [3:0] lo_rev;

   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   // mirror abort and line-out enables; enables turned round so bit0 is channel 1
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         abort_q <= 1'h0;
         lo_rev  <= 4'h0;
      end else if (REG_WE && REG_ADDR == 8'h05) begin
         abort_q <= REG_WDATA[7];
      end else if (REG_WE && REG_ADDR == 8'h06) begin
         lo_rev <= {REG_WDATA[0], REG_WDATA[1], REG_WDATA[2], REG_WDATA[3]};
      end
   end

   a_idle_quiet: assert property (!DIAG_BUSY |-> DIAG_CH == 4'h0 && !STEP_RAMP && !STEP_AVG)
      else $error("step output active while idle");
   a_done_ends_run: assert property (DIAG_DONE |-> !DIAG_BUSY && $past(DIAG_BUSY))
      else $error("done pulse outside the end of a run");
   a_ramp_then_settle: assert property ($fell(STEP_RAMP) && DIAG_BUSY |-> STEP_SETTLE && $stable(PHASE_LOAD))
      else $error("ramp not followed by settling");
   a_settle_then_avg: assert property ($fell(STEP_SETTLE) && DIAG_BUSY |-> STEP_AVG && $stable(PHASE_LOAD))
      else $error("settling not followed by averaging");
   a_rail_before_load: assert property ($rose(PHASE_LOAD) |-> STEP_RAMP && $past(STEP_AVG))
      else $error("load phase entered out of order");
   a_lineout_gated: assert property (LINEOUT_CHECK == ((STEP_AVG && PHASE_LOAD) ? DIAG_CH & lo_rev : 4'h0))
      else $error("line-out check on wrong channels");
   a_thresh_follows: assert property (REG_WE && REG_ADDR == 8'h08 |=> ##[0:1]
      {SHORT_THRESH_1, SHORT_THRESH_2} == $past(REG_WDATA, 2))
      else $error("threshold outputs do not follow the write");
   a_abort_stops: assert property (REG_WE && REG_ADDR == 8'h05 && REG_WDATA[7] |-> ##[1:2] !DIAG_BUSY)
      else $error("abort did not stop the run");
   a_abort_holds: assert property (abort_q && $past(abort_q) |-> !DIAG_BUSY && !DIAG_DONE)
      else $error("sequencer active while abort set");
   a_manual_start: assert property (REG_WE && REG_ADDR == 8'h04 && REG_WDATA[7:6] == 2'h3 && !DIAG_BUSY
      && !abort_q |-> ##[1:4] DIAG_BUSY && DIAG_CH[0])
      else $error("channel request did not start a run");

   c_done: cover property (DIAG_DONE);
   c_load_phase: cover property ($rose(PHASE_LOAD));
   c_aborted: cover property ($fell(DIAG_BUSY) && !DIAG_DONE);
endmodule // dld_chk

bind dld_top dld_chk dld_chk_inst (.CLOCK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WE, .DIAG_BUSY, .DIAG_DONE,
   .DIAG_CH, .PHASE_LOAD, .STEP_RAMP, .STEP_SETTLE, .STEP_AVG, .LINEOUT_CHECK, .SHORT_THRESH_1, .SHORT_THRESH_2);

// ---- test/dld_load_model.sv ----
// output stages and loads answering the diagnostic measurements
`timescale 1ns/10ps
module dld_load_model (
   // clock
   input  wire logic       clk,
   // sequencer state
   input  wire logic       phase_load,
   input  wire logic       step_avg,
   // load conditions, bit0 is channel 1
   input  wire logic [3:0] gnd_cfg,
   input  wire logic [3:0] sup_cfg,
   input  wire logic [3:0] open_cfg,
   input  wire logic [3:0] short_cfg,
   input  wire logic [3:0] lo_cfg,
   // comparator levels
   output logic      [3:0] meas_gnd,
   output logic      [3:0] meas_sup,
   output logic      [3:0] meas_open,
   output logic      [3:0] meas_short,
   output logic      [3:0] meas_lo
);
   logic tog;

   initial tog = 1'h0;
   // outside averaging the comparators are not settled, so they wander each cycle
   always @(posedge clk) tog <= ~tog;

   // rail results valid only in rail averaging, load results only in load averaging
   assign meas_gnd   = (step_avg && !phase_load) ? gnd_cfg : {4{tog}};
   assign meas_sup   = (step_avg && !phase_load) ? sup_cfg : {4{~tog}};
   assign meas_open  = (step_avg && phase_load) ? open_cfg : {4{tog}};
   assign meas_short = (step_avg && phase_load) ? short_cfg : {4{~tog}};
   assign meas_lo    = (step_avg && phase_load) ? lo_cfg : {4{tog}};
endmodule // dld_load_model

// ---- test/dc_load_diag_control_tb_top.sv ----
// self-checking bench of the load diagnostic control
`timescale 1ns/10ps
module dc_load_diag_control_tb_top;
   logic       clock, sys_rst, reg_we, reg_re, busy, done, ph_load, s_ramp, s_settle, s_avg, saw_load;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] hiz, fault, m_gnd, m_sup, m_open, m_short, m_lo, d_ch, lo_chk, th1, th2, ch_seen;
   logic [3:0] c_gnd, c_sup, c_open, c_short, c_lo;
   logic [4:0] key, prev, tail;
   int         fail_count, num_checks, cnt, done_n, n, i;
   int         len[32];

   always #4 clock = ~clock;

   // tiny prescaler: one cycle per microsecond keeps the runs short
   dld_top #(.CYC_PER_US(8'h01)) dld_top_inst (.CLOCK(clock), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .CH_HIZ_EXIT(hiz),
      .CH_FAULT(fault), .MEAS_GND_SHORT(m_gnd), .MEAS_SUPPLY_SHORT(m_sup), .MEAS_OPEN(m_open),
      .MEAS_SHORTED(m_short), .MEAS_LINEOUT(m_lo), .DIAG_BUSY(busy), .DIAG_DONE(done), .DIAG_CH(d_ch),
      .PHASE_LOAD(ph_load), .STEP_RAMP(s_ramp), .STEP_SETTLE(s_settle), .STEP_AVG(s_avg),
      .LINEOUT_CHECK(lo_chk), .SHORT_THRESH_1(th1), .SHORT_THRESH_2(th2));

   dld_load_model dld_load_model_inst (.clk(clock), .phase_load(ph_load), .step_avg(s_avg), .gnd_cfg(c_gnd),
      .sup_cfg(c_sup), .open_cfg(c_open), .short_cfg(c_short), .lo_cfg(c_lo), .meas_gnd(m_gnd),
      .meas_sup(m_sup), .meas_open(m_open), .meas_short(m_short), .meas_lo(m_lo));

   // step durations keyed by {busy, load phase, avg, settle, ramp}; tail is the last busy key
   always @(posedge clock) begin
      if (!sys_rst) begin
         key = {busy, ph_load, s_avg, s_settle, s_ramp};
         if (key == prev) begin
            cnt++;
         end else begin
            len[prev] = cnt;
            if (!key[4]) tail = prev;
            cnt = 1;
            prev = key;
         end
         if (ph_load) saw_load = 1'h1;
         if (busy) ch_seen = d_ch;
         if (done) done_n++;
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a timed step may carry a few cycles of entry overhead
   task chk_len(input int got, input int t);
      num_checks++;
      if (got < t || got > t + 3) begin
         fail_count++;
         $display("mismatch at %0t: step of %0d cycles, expected %0d", $time, got, t);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'h1;
      @(posedge clock);
      reg_we    <= 1'h0;
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_re   <= 1'h1;
      @(posedge clock);
      reg_re   <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask

   task pulse(input logic [3:0] h, input logic [3:0] f);
      @(posedge clock);
      hiz   <= h;
      fault <= f;
      @(posedge clock);
      hiz   <= 4'h0;
      fault <= 4'h0;
   endtask

   task wait_run(input int lim);
      for (i = 0; i < 10 && busy !== 1'h1; i++) @(posedge clock);
      for (i = 0; i < lim && busy !== 1'h0; i++) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
      @(posedge clock);
   endtask

   task t_regs;
      rd_chk(8'h04, 8'h55);
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h06, 8'h00);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h08, 8'h11);
      chk({th1, th2}, 8'h11);
      wr(8'h08, 8'h93);
      wr(8'h0A, 8'hFF);
      wr(8'h20, 8'h5A);
      rd_chk(8'h08, 8'h93);
      chk({th1, th2}, 8'h93);
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h20, 8'h00);
   endtask

   // channels 1 and 2 by hand, both phases and the end wait
   task t_full;
      c_gnd <= 4'h1;
      c_open <= 4'h2;
      c_short <= 4'h1;
      c_lo <= 4'h3;
      wr(8'h05, 8'h00);
      wr(8'h06, 8'h0A);
      wr(8'h07, 8'h95);
      wr(8'h04, 8'hF5);
      wait_run(30000);
      chk({4'h0, ch_seen}, 8'h03);
      chk_len(len[5'h11], 2500);
      chk_len(len[5'h12], 5000);
      chk_len(len[5'h14], 200);
      chk_len(len[5'h19], 10000);
      chk_len(len[5'h1A], 5000);
      chk_len(len[5'h1C], 200);
      chk_len(len[5'h10], 1000);
      chk({3'h0, tail}, 8'h10);
      rd_chk(8'h0A, 8'h92);
      rd_chk(8'h0C, 8'h08);
      chk(8'(done_n), 8'h01);
   endtask

   // channel 3 leaves high impedance with load detection and end wait skipped
   task t_auto;
      c_sup <= 4'h4;
      saw_load = 1'h0;
      wr(8'h05, 8'h26);
      wr(8'h06, 8'h40);
      wr(8'h07, 8'h05);
      pulse(4'h4, 4'h0);
      wait_run(15000);
      chk({4'h0, ch_seen}, 8'h04);
      chk_len(len[5'h10], 2000);
      chk_len(len[5'h14], 700);
      chk({7'h0, saw_load}, 8'h00);
      chk({3'h0, tail}, 8'h14);
      rd_chk(8'h0B, 8'h40);
      wr(8'h05, 8'h27);
      pulse(4'h2, 4'h1);
      repeat (20) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
   endtask

   // fault start, then abort in mid-run; requests under abort are dropped
   task t_abort;
      wr(8'h05, 8'h06);
      pulse(4'h0, 4'h2);
      for (i = 0; i < 10 && busy !== 1'h1; i++) @(posedge clock);
      chk({4'h0, d_ch}, 8'h02);
      repeat (100) @(posedge clock);
      n = done_n;
      wr(8'h05, 8'h86);
      repeat (3) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
      wr(8'h04, 8'hD5);
      repeat (5) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
      wr(8'h05, 8'h06);
      repeat (5) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
      chk(8'(done_n), 8'(n));
   endtask

   task wrap_up;
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      {clock, sys_rst} = 2'h1;
      {reg_we, reg_re, reg_addr, reg_wdata, hiz, fault} = 26'h0;
      {c_gnd, c_sup, c_open, c_short, c_lo} = 20'h0;
      {fail_count, num_checks, cnt, done_n} = 128'h0;
      {prev, tail} = 10'h0;
      repeat (16) @(posedge clock);
      sys_rst <= 1'h0;
      t_regs;
      t_full;
      t_auto;
      t_abort;
      wrap_up;
   end

   // runs take about 35000 cycles
   initial begin
      repeat (60000) @(posedge clock);
      fail_count++;
      $display("mismatch at %0t: run did not finish", $time);
      wrap_up;
   end
endmodule // dc_load_diag_control_tb_top
